/* nvac_ctrl.v */
`timescale 1ns/1ps
`include "nvac_consts.vh"
// ==========================================================
// Overview of operation
// - select bit picks program or data space
// - select bit zero at reset, frozen while writing
// - read/write strobes set-only, hardware clears them
// - writes need write permit, permit clear at reset
// - warm reset during write sets abort flag
// - warm reset keeps data and address registers
// - done flag set on completion, software clears
// - unlock port has no storage, reads zero
// - data read result ready next cycle
// - data register holds until read or write
// - small data part wraps 80h-FFh to start
// - unimplemented data write keeps pump off
// - data pair 14 bits, address pair 13 bits
// - program addresses beyond part size wrap around
// - word reads, four-word block writes with erase
// - data byte write erases before programming
// - write length set by internal timer
// - code protect keeps core access, honours protect
// - code protect denies programming port access
// - data uses low address, program uses both
// - small data part ignores top address bit
// - control bits 6 to 4 read zero
// - write needs 55h then AAh then strobe
// - strobe needs permit set; later clear harmless
// - program read stalls core two cycles
module nvac_ctrl #(
  parameter [`NVAC_TMR_W-1:0] WRITE_CYCLES =
    `NVAC_WRITE_CYCLES
) (
  // Clock and power-on reset
  input wire CLK_SYS_IN,
  input wire RST_IN,
  // Core register port
  input wire [`NVAC_BUS_AW-1:0] BUS_ADDR_IN,
  input wire BUS_WE_IN,
  input wire BUS_RE_IN,
  input wire [`NVAC_DW-1:0] BUS_WDATA_IN,
  output wire [`NVAC_DW-1:0] BUS_RDATA_OUT,
  // Warm resets
  input wire EXT_MASTER_RESET_IN,
  input wire WATCHDOG_TIMEOUT_IN,
  // Part size straps
  input wire DATA_SMALL_IN,
  input wire PROG_SMALL_IN,
  // Protection settings
  input wire CODE_PROTECT_IN,
  input wire PROG_WP_EN_IN,
  input wire [`NVAC_PAW-1:0] PROG_WP_TOP_IN,
  // Status
  output wire WRITE_BUSY_OUT,
  output wire CHARGE_PUMP_ON_OUT,
  output wire CORE_IGNORE_OUT,
  output wire WRITE_DONE_IRQ_FLAG_OUT,
  // Programming port
  input wire PGM_RD_IN,
  input wire PGM_SPACE_IN,
  input wire [`NVAC_PAW-1:0] PGM_ADDR_IN,
  output wire [`NVAC_PDW-1:0] PGM_RDATA_OUT,
  output wire PGM_DENIED_OUT
);

  // ========================================================
  // State codes
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_ERASE = 2'h1;
  localparam [1:0] S_TIMED = 2'h2;
  localparam [1:0] S_PROG = 2'h3;
  localparam [1:0] UL_NONE = 2'h0;
  localparam [1:0] UL_KEY1 = 2'h1;
  localparam [1:0] UL_ARMED = 2'h2;

  // ========================================================
  // Storage
  reg mrst_s1_r;
  reg mrst_s2_r;
  reg dsm_s1_r;
  reg dsm_s2_r;
  reg psm_s1_r;
  reg psm_s2_r;
  reg [`NVAC_DW-1:0] data_lo_r;
  reg [`NVAC_DHI_W-1:0] data_hi_r;
  reg [`NVAC_DAW-1:0] addr_lo_r;
  reg [`NVAC_AHI_W-1:0] addr_hi_r;
  reg psel_r;
  reg abort_r;
  reg permit_r;
  reg wr_r;
  reg rd_r;
  reg rd_prog_r;
  reg [1:0] rd_cnt_r;
  reg done_r;
  reg [1:0] ul_r;
  reg [1:0] ul_nxt;
  reg [1:0] state_r;
  reg [1:0] idx_r;
  reg [1:0] last_r;
  reg tgt_prog_r;
  reg skip_r;
  reg [`NVAC_PAW-1:0] tgt_r;
  reg [`NVAC_TMR_W-1:0] tmr_r;
  reg [`NVAC_PDW-1:0] buf_r [0:3];
  reg [`NVAC_DW-1:0] rdata_r;
  reg [`NVAC_DW-1:0] rdata_nxt;
  reg [`NVAC_PDW-1:0] pgm_rdata_r;
  reg pgm_denied_r;

  // ========================================================
  // Decode and address shaping
  wire warm = mrst_s2_r | WATCHDOG_TIMEOUT_IN;
  wire busy = (state_r != S_IDLE);
  wire wr_ctrl = BUS_WE_IN && (BUS_ADDR_IN == `NVAC_OFS_CTRL);
  wire [`NVAC_DW-1:0] wd = BUS_WDATA_IN;
  // Small data part drops the top address bit
  wire [`NVAC_DAW-1:0] da = addr_lo_r &
    (dsm_s2_r ? `NVAC_DA_MASK_S : `NVAC_DA_MASK_L);
  // Program word address from both address registers
  wire [`NVAC_PAW-1:0] pa = {addr_hi_r, addr_lo_r} &
    (psm_s2_r ? `NVAC_PA_MASK_S : `NVAC_PA_MASK_L);
  wire [1:0] slot = pa[1:0];
  wire [`NVAC_PAW-1:0] blk = {pa[`NVAC_PAW-1:2], `NVAC_BLK_FIRST};
  wire [`NVAC_PDW-1:0] cur_word = {data_hi_r, data_lo_r};
  // Protected block refuses core writes, whatever code protect says
  wire p_prot = PROG_WP_EN_IN && (blk <= PROG_WP_TOP_IN);
  // Select bit as seen by this write
  wire psel_new = busy ? psel_r : wd[`NVAC_B_PSEL];
  wire wr_req = wr_ctrl && wd[`NVAC_B_WR] && !busy && !warm;
  // Needs prior permit and an armed unlock sequence
  wire wr_ok = wr_req && permit_r && (ul_r == UL_ARMED);
  wire blk_load = wr_ok && psel_new && (slot != `NVAC_BLK_LAST);
  wire wr_start = wr_ok && !(psel_new && ((slot != `NVAC_BLK_LAST) || p_prot));
  wire rd_start = wr_ctrl && wd[`NVAC_B_RD] && !busy && !rd_r && !warm && !wr_ok;
  wire rd_end = rd_r && (rd_cnt_r == `NVAC_RD_CYC_DATA);
  wire wr_end = (state_r == S_PROG) && (idx_r == last_r);

  // ========================================================
  // Memory write datapath
  wire cell_we = ((state_r == S_ERASE) || (state_r == S_PROG)) && !skip_r;
  wire erasing = (state_r == S_ERASE);
  wire [`NVAC_PAW-1:0] p_waddr = tgt_r + {{(`NVAC_PAW-2){1'b0}}, idx_r};
  wire [`NVAC_PDW-1:0] p_wdata = erasing ? `NVAC_ERASED_P : buf_r[idx_r];
  wire [`NVAC_DW-1:0] d_wdata = erasing ? `NVAC_ERASED_D : buf_r[0][`NVAC_DW-1:0];
  wire [`NVAC_DW-1:0] d_rdata;
  wire [`NVAC_DW-1:0] d_pgm_rdata;
  wire [`NVAC_PDW-1:0] p_rdata;
  wire [`NVAC_PDW-1:0] p_pgm_rdata;
  wire [`NVAC_DAW-1:0] pgm_da = PGM_ADDR_IN[`NVAC_DAW-1:0] &
    (dsm_s2_r ? `NVAC_DA_MASK_S : `NVAC_DA_MASK_L);
  wire [`NVAC_PAW-1:0] pgm_pa = PGM_ADDR_IN &
    (psm_s2_r ? `NVAC_PA_MASK_S : `NVAC_PA_MASK_L);

  // Data space array
  nvac_mem #(.W(`NVAC_DW), .AW(`NVAC_DAW)) u_dmem (
    .clk_in(CLK_SYS_IN),
    .we_in(cell_we && !tgt_prog_r),
    .waddr_in(tgt_r[`NVAC_DAW-1:0]),
    .wdata_in(d_wdata),
    .raddr_a_in(da),
    .rdata_a_out(d_rdata),
    .raddr_b_in(pgm_da),
    .rdata_b_out(d_pgm_rdata)
  );

  // Program space array
  nvac_mem #(.W(`NVAC_PDW), .AW(`NVAC_PAW)) u_pmem (
    .clk_in(CLK_SYS_IN),
    .we_in(cell_we && tgt_prog_r),
    .waddr_in(p_waddr),
    .wdata_in(p_wdata),
    .raddr_a_in(pa),
    .rdata_a_out(p_rdata),
    .raddr_b_in(pgm_pa),
    .rdata_b_out(p_pgm_rdata)
  );

  // ========================================================
  // Pin synchronisers
  always @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      mrst_s1_r <= 1'b0;
      mrst_s2_r <= 1'b0;
      dsm_s1_r <= 1'b0;
      dsm_s2_r <= 1'b0;
      psm_s1_r <= 1'b0;
      psm_s2_r <= 1'b0;
    end else begin
      mrst_s1_r <= EXT_MASTER_RESET_IN;
      mrst_s2_r <= mrst_s1_r;
      dsm_s1_r <= DATA_SMALL_IN;
      dsm_s2_r <= dsm_s1_r;
      psm_s1_r <= PROG_SMALL_IN;
      psm_s2_r <= psm_s1_r;
    end
  end

  // ========================================================
  // Unlock sequence tracker; any other write disarms it
  always @* begin
    ul_nxt = UL_NONE;
    if (warm) begin
      ul_nxt = UL_NONE;
    end else if (BUS_WE_IN && (BUS_ADDR_IN == `NVAC_OFS_UNLOCK)) begin
      if ((ul_r == UL_KEY1) && (wd == `NVAC_KEY2)) begin
        ul_nxt = UL_ARMED;
      end else if (wd == `NVAC_KEY1) begin
        ul_nxt = UL_KEY1;
      end else begin
        ul_nxt = UL_NONE;
      end
    end else if (BUS_WE_IN) begin
      ul_nxt = UL_NONE;
    end else begin
      ul_nxt = ul_r;
    end
  end

  // ========================================================
  // Address and data holding registers
  always @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      data_lo_r <= `NVAC_ZERO8;
      data_hi_r <= {`NVAC_DHI_W{1'b0}};
      addr_lo_r <= `NVAC_ZERO8;
      addr_hi_r <= {`NVAC_AHI_W{1'b0}};
    end else if (rd_end) begin
      // Read result replaces the held value
      if (rd_prog_r) begin
        {data_hi_r, data_lo_r} <= p_rdata;
      end else begin
        data_lo_r <= d_rdata;
      end
    end else if (BUS_WE_IN) begin
      // Warm resets leave these untouched
      if (BUS_ADDR_IN == `NVAC_OFS_DATA_LO) begin
        data_lo_r <= wd;
      end
      if (BUS_ADDR_IN == `NVAC_OFS_DATA_HI) begin
        data_hi_r <= wd[`NVAC_DHI_W-1:0];
      end
      if (BUS_ADDR_IN == `NVAC_OFS_ADDR_LO) begin
        addr_lo_r <= wd;
      end
      if (BUS_ADDR_IN == `NVAC_OFS_ADDR_HI) begin
        addr_hi_r <= wd[`NVAC_AHI_W-1:0];
      end
    end
  end

  // ========================================================
  // Four-word write buffer
  always @(posedge CLK_SYS_IN) begin
    if (blk_load) begin
      buf_r[slot] <= cur_word;
    end else if (wr_start && psel_new) begin
      buf_r[`NVAC_BLK_LAST] <= cur_word;
    end else if (wr_start) begin
      buf_r[0] <= {{(`NVAC_PDW-`NVAC_DW){1'b0}}, data_lo_r};
    end
  end

  // ========================================================
  // Control bits, strobes, flags and unlock state
  always @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      psel_r <= 1'b0;
      abort_r <= 1'b0;
      permit_r <= 1'b0;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      rd_prog_r <= 1'b0;
      rd_cnt_r <= 2'h0;
      done_r <= 1'b0;
      ul_r <= UL_NONE;
    end else begin
      ul_r <= ul_nxt;
      if (warm) begin
        // Warm reset clears control but not the error flag
        psel_r <= 1'b0;
        permit_r <= 1'b0;
        wr_r <= 1'b0;
        rd_r <= 1'b0;
        rd_cnt_r <= 2'h0;
        if (busy) begin
          abort_r <= 1'b1;
        end
      end else begin
        if (wr_ctrl) begin
          psel_r <= psel_new;
          permit_r <= wd[`NVAC_B_PERMIT];
          abort_r <= wd[`NVAC_B_ABORT];
        end
        // Software can only set; completion clears
        if (wr_start) begin
          wr_r <= 1'b1;
        end else if (wr_end) begin
          wr_r <= 1'b0;
        end
        if (rd_start) begin
          rd_r <= 1'b1;
          rd_prog_r <= psel_new;
          rd_cnt_r <= psel_new ? `NVAC_RD_CYC_PROG : `NVAC_RD_CYC_DATA;
        end else if (rd_end) begin
          rd_r <= 1'b0;
          rd_cnt_r <= 2'h0;
        end else if (rd_r) begin
          rd_cnt_r <= rd_cnt_r - 2'h1;
        end
      end
      // Completion set wins over a same-cycle software clear
      if (wr_end && !warm) begin
        done_r <= 1'b1;
      end else if (BUS_WE_IN && (BUS_ADDR_IN == `NVAC_OFS_IRQ2)) begin
        done_r <= wd[`NVAC_B_DONE];
      end
    end
  end

  // ========================================================
  // Self-timed erase and program sequencer
  always @(posedge CLK_SYS_IN) begin
    if (RST_IN || warm) begin
      state_r <= S_IDLE;
      idx_r <= 2'h0;
      last_r <= 2'h0;
      tgt_prog_r <= 1'b0;
      skip_r <= 1'b0;
      tgt_r <= {`NVAC_PAW{1'b0}};
      tmr_r <= {`NVAC_TMR_W{1'b0}};
    end else begin
      case (state_r)
        S_IDLE: begin
          idx_r <= 2'h0;
          if (wr_start) begin
            state_r <= S_ERASE;
            tgt_prog_r <= psel_new;
            tgt_r <= psel_new ? blk : {{(`NVAC_PAW-`NVAC_DAW){1'b0}}, addr_lo_r};
            last_r <= psel_new ? `NVAC_BLK_LAST : `NVAC_BLK_FIRST;
            // Unimplemented data location: no cell change, pump stays off
            skip_r <= !psel_new && dsm_s2_r && addr_lo_r[`NVAC_DA_TOP];
          end
        end
        S_ERASE: begin
          if (idx_r == last_r) begin
            idx_r <= 2'h0;
            tmr_r <= WRITE_CYCLES;
            state_r <= S_TIMED;
          end else begin
            idx_r <= idx_r + 2'h1;
          end
        end
        S_TIMED: begin
          // Busy for the whole timed count
          if (tmr_r <= {{(`NVAC_TMR_W-1){1'b0}}, 1'b1}) begin
            state_r <= S_PROG;
          end else begin
            tmr_r <= tmr_r - {{(`NVAC_TMR_W-1){1'b0}}, 1'b1};
          end
        end
        S_PROG: begin
          if (idx_r == last_r) begin
            state_r <= S_IDLE;
          end else begin
            idx_r <= idx_r + 2'h1;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // ========================================================
  // Register read mux
  always @* begin
    rdata_nxt = `NVAC_ZERO8;
    case (BUS_ADDR_IN)
      `NVAC_OFS_CTRL: begin
        rdata_nxt[`NVAC_B_PSEL] = psel_r;
        rdata_nxt[`NVAC_B_ABORT] = abort_r;
        rdata_nxt[`NVAC_B_PERMIT] = permit_r;
        rdata_nxt[`NVAC_B_WR] = wr_r;
        rdata_nxt[`NVAC_B_RD] = rd_r;
      end
      `NVAC_OFS_IRQ2: begin
        rdata_nxt[`NVAC_B_DONE] = done_r;
      end
      `NVAC_OFS_DATA_LO: begin
        rdata_nxt = data_lo_r;
      end
      `NVAC_OFS_DATA_HI: begin
        rdata_nxt[`NVAC_DHI_W-1:0] = data_hi_r;
      end
      `NVAC_OFS_ADDR_LO: begin
        rdata_nxt = addr_lo_r;
      end
      `NVAC_OFS_ADDR_HI: begin
        rdata_nxt[`NVAC_AHI_W-1:0] = addr_hi_r;
      end
      `NVAC_OFS_UNLOCK: begin
        rdata_nxt = `NVAC_ZERO8;
      end
      default: begin
        rdata_nxt = `NVAC_ZERO8;
      end
    endcase
  end

  // ========================================================
  // Registered read data and programming port
  always @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      rdata_r <= `NVAC_ZERO8;
      pgm_rdata_r <= `NVAC_ZERO14;
      pgm_denied_r <= 1'b0;
    end else begin
      if (BUS_RE_IN) begin
        rdata_r <= rdata_nxt;
      end
      if (PGM_RD_IN) begin
        if (CODE_PROTECT_IN) begin
          pgm_rdata_r <= `NVAC_ZERO14;
          pgm_denied_r <= 1'b1;
        end else begin
          pgm_rdata_r <= PGM_SPACE_IN ? p_pgm_rdata :
            {{(`NVAC_PDW-`NVAC_DW){1'b0}}, d_pgm_rdata};
          pgm_denied_r <= 1'b0;
        end
      end
    end
  end

  // ========================================================
  // Outputs
  assign BUS_RDATA_OUT = rdata_r;
  assign WRITE_BUSY_OUT = busy;
  assign CHARGE_PUMP_ON_OUT = busy && !skip_r;
  assign CORE_IGNORE_OUT = rd_r && rd_prog_r;
  assign WRITE_DONE_IRQ_FLAG_OUT = done_r;
  assign PGM_RDATA_OUT = pgm_rdata_r;
  assign PGM_DENIED_OUT = pgm_denied_r;

endmodule

/* nvac_consts.vh */
`ifndef NVAC_CONSTS_VH
`define NVAC_CONSTS_VH
// ==========================================================
// Register file addresses (9-bit core file address)
`define NVAC_OFS_IRQ2 9'h00D
`define NVAC_OFS_DATA_LO 9'h10C
`define NVAC_OFS_ADDR_LO 9'h10D
`define NVAC_OFS_DATA_HI 9'h10E
`define NVAC_OFS_ADDR_HI 9'h10F
`define NVAC_OFS_CTRL 9'h18C
`define NVAC_OFS_UNLOCK 9'h18D
// ==========================================================
// Control register bit positions
`define NVAC_B_RD 0
`define NVAC_B_WR 1
`define NVAC_B_PERMIT 2
`define NVAC_B_ABORT 3
`define NVAC_B_PSEL 7
// Done flag position in the flag register
`define NVAC_B_DONE 4
// ==========================================================
// Widths and sizes
`define NVAC_BUS_AW 9
`define NVAC_DW 8
`define NVAC_DAW 8
`define NVAC_PDW 14
`define NVAC_PAW 13
`define NVAC_DHI_W 6
`define NVAC_AHI_W 5
`define NVAC_TMR_W 20
// Address masks for small and large parts
`define NVAC_DA_MASK_S 8'h7F
`define NVAC_DA_MASK_L 8'hFF
`define NVAC_DA_TOP 7
`define NVAC_PA_MASK_S 13'h0FFF
`define NVAC_PA_MASK_L 13'h1FFF
// Four-word program block
`define NVAC_BLK_FIRST 2'h0
`define NVAC_BLK_LAST 2'h3
// ==========================================================
// Values and keys
`define NVAC_KEY1 8'h55
`define NVAC_KEY2 8'hAA
`define NVAC_ERASED_D 8'hFF
`define NVAC_ERASED_P 14'h3FFF
`define NVAC_ZERO8 8'h00
`define NVAC_ZERO14 14'h0000
`define NVAC_RD_CYC_DATA 2'h1
`define NVAC_RD_CYC_PROG 2'h2
// ==========================================================
// Timing
`define NVAC_CLK_PERIOD_NS 5
`define NVAC_WRITE_TIME_NS 4000000
// Default self-timed write length in core cycles (4 ms at 5 ns)
`define NVAC_WRITE_CYCLES 20'hC3500
`endif

/* nvac_mem.v */
`timescale 1ns/1ps
// ==========================================================
// Nonvolatile array model: flip-flop storage, one write port,
// two combinational read ports; no reset so content survives
module nvac_mem #(
  parameter W = 8,
  parameter AW = 8
) (
  // Clock
  input wire clk_in,
  // Write port
  input wire we_in,
  input wire [AW-1:0] waddr_in,
  input wire [W-1:0] wdata_in,
  // Read ports
  input wire [AW-1:0] raddr_a_in,
  output wire [W-1:0] rdata_a_out,
  input wire [AW-1:0] raddr_b_in,
  output wire [W-1:0] rdata_b_out
);

  reg [W-1:0] mem_r [0:(1<<AW)-1];

  // Cell update
  always @(posedge clk_in) begin
    if (we_in) begin
      mem_r[waddr_in] <= wdata_in;
    end
  end

  // Read paths
  assign rdata_a_out = mem_r[raddr_a_in];
  assign rdata_b_out = mem_r[raddr_b_in];

endmodule

/* nvac_cpu.sv */
`timescale 1ns/1ps
// ==========================================================
// Core model: register reads and writes on the file bus
module nvac_cpu (
  // Clock
  input wire clk_in,
  // Register bus
  output logic [8:0] addr_out,
  output logic we_out,
  output logic re_out,
  output logic [7:0] wdata_out,
  input wire [7:0] rdata_in
);
  // Idle bus from time zero
  initial begin
    addr_out = 9'h000;
    we_out = 1'b0;
    re_out = 1'b0;
    wdata_out = 8'h00;
  end
  // One write, taken at the edge that sees the strobe
  task automatic wr(input [8:0] a, input [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    we_out <= 1'b1;
    @(posedge clk_in);
    we_out <= 1'b0;
    wdata_out <= ~d; // Released data never keeps the last value
  endtask
  // One read, answer settled after the taking edge
  task automatic rd(input [8:0] a, output [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    re_out <= 1'b1;
    @(posedge clk_in);
    re_out <= 1'b0;
    #1 d = rdata_in;
  endtask
  // Arming pair, then the control write that sets the strobe
  task automatic unl(input [7:0] c);
    wr(9'h18D, 8'h55);
    wr(9'h18D, 8'hAA);
    wr(9'h18C, c);
  endtask
endmodule

/* nvac_ctrl_props.sv */
`timescale 1ns/1ps
// ==========================================================
// Port checks for the access controller
module nvac_ctrl_props #(
  parameter [19:0] WRITE_CYCLES = 20'hC3500
) (
  // Clock, resets and bus
  input wire CLK_SYS_IN,
  input wire RST_IN,
  input wire EXT_MASTER_RESET_IN,
  input wire WATCHDOG_TIMEOUT_IN,
  input wire [8:0] BUS_ADDR_IN,
  input wire BUS_WE_IN,
  input wire BUS_RE_IN,
  input wire [7:0] BUS_WDATA_IN,
  input wire [7:0] BUS_RDATA_OUT,
  // Status and programming port
  input wire WRITE_BUSY_OUT,
  input wire CHARGE_PUMP_ON_OUT,
  input wire CORE_IGNORE_OUT,
  input wire WRITE_DONE_IRQ_FLAG_OUT,
  input wire [13:0] PGM_RDATA_OUT,
  input wire PGM_DENIED_OUT
);
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (RST_IN);
  // Busy span length and warm-reset abort seen
  logic [19:0] len_r;
  logic abort_r;
  always @(posedge CLK_SYS_IN) begin
    if (RST_IN || !WRITE_BUSY_OUT) begin
      len_r <= 20'h00000;
      abort_r <= 1'b0;
    end else begin
      len_r <= len_r + 20'h00001;
      abort_r <= abort_r | EXT_MASTER_RESET_IN | WATCHDOG_TIMEOUT_IN;
    end
  end
  busy_len_a: assert property ($fell(WRITE_BUSY_OUT) && !abort_r |->
    len_r == WRITE_CYCLES + 20'h00002 || len_r == WRITE_CYCLES + 20'h00008)
    else $error("Write busy span has wrong length");
  done_set_a: assert property ($fell(WRITE_BUSY_OUT) && !abort_r |->
    WRITE_DONE_IRQ_FLAG_OUT) else $error("Done flag not set at write end");
  done_hold_a: assert property ($fell(WRITE_DONE_IRQ_FLAG_OUT) |-> $past(RST_IN) ||
    $past(BUS_WE_IN) && $past(BUS_ADDR_IN) == 9'h00D) else $error("Done flag lost");
  ign_len_a: assert property ($rose(CORE_IGNORE_OUT) |=>
    CORE_IGNORE_OUT ##1 !CORE_IGNORE_OUT) else $error("Ignore window not two cycles");
  ign_cause_a: assert property ($rose(CORE_IGNORE_OUT) |-> $past(BUS_WE_IN) &&
    $past(BUS_ADDR_IN) == 9'h18C && ($past(BUS_WDATA_IN) & 8'h01) != 8'h00)
    else $error("Ignore window without read strobe");
  busy_cause_a: assert property ($rose(WRITE_BUSY_OUT) |-> $past(BUS_WE_IN) &&
    $past(BUS_ADDR_IN) == 9'h18C && ($past(BUS_WDATA_IN) & 8'h02) != 8'h00)
    else $error("Write started without strobe");
  pump_busy_a: assert property (CHARGE_PUMP_ON_OUT |-> WRITE_BUSY_OUT)
    else $error("Pump on outside a write");
  rd_hold_a: assert property (!$past(BUS_RE_IN) |-> $stable(BUS_RDATA_OUT))
    else $error("Read data changed without a read");
  unlock_zero_a: assert property ($past(BUS_RE_IN) &&
    $past(BUS_ADDR_IN) == 9'h18D |-> BUS_RDATA_OUT == 8'h00)
    else $error("Unlock port read not zero");
  ctrl_gap_a: assert property ($past(BUS_RE_IN) &&
    $past(BUS_ADDR_IN) == 9'h18C |-> (BUS_RDATA_OUT & 8'h70) == 8'h00)
    else $error("Control gap bits not zero");
  deny_zero_a: assert property (PGM_DENIED_OUT |-> PGM_RDATA_OUT == 14'h0000)
    else $error("Denied read returned data");
endmodule

bind nvac_ctrl nvac_ctrl_props #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (
  .CLK_SYS_IN, .RST_IN, .EXT_MASTER_RESET_IN, .WATCHDOG_TIMEOUT_IN,
  .BUS_ADDR_IN, .BUS_WE_IN, .BUS_RE_IN, .BUS_WDATA_IN, .BUS_RDATA_OUT,
  .WRITE_BUSY_OUT, .CHARGE_PUMP_ON_OUT, .CORE_IGNORE_OUT,
  .WRITE_DONE_IRQ_FLAG_OUT, .PGM_RDATA_OUT, .PGM_DENIED_OUT
);

/* tb_nv_memory_access_ctrl.sv */
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the access controller
module tb_nv_memory_access_ctrl;
  logic clk, rst, ext_rst, wdog, dsmall, psmall, cprot, pgm_rd, pseen, wp_en, pgm_sp;
  logic [12:0] pgm_addr, pa;
  wire [8:0] baddr;
  wire bwe, bre, busy, pump, ign, done, denied;
  wire [7:0] bwd, brd;
  wire [13:0] pgm_rdata;
  integer bad_count = 0, check_count = 0, seed = 32'hd34f9992;
  integer dm[0:255];
  integer pm[0:3];
  logic [7:0] a, a0, d, r;
  logic [13:0] w;
  // Clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  nvac_ctrl #(.WRITE_CYCLES(20'h00008)) uut (
    .CLK_SYS_IN(clk), .RST_IN(rst), .BUS_ADDR_IN(baddr), .BUS_WE_IN(bwe),
    .BUS_RE_IN(bre), .BUS_WDATA_IN(bwd), .BUS_RDATA_OUT(brd),
    .EXT_MASTER_RESET_IN(ext_rst), .WATCHDOG_TIMEOUT_IN(wdog),
    .DATA_SMALL_IN(dsmall), .PROG_SMALL_IN(psmall), .CODE_PROTECT_IN(cprot),
    .PROG_WP_EN_IN(wp_en), .PROG_WP_TOP_IN(pa), .WRITE_BUSY_OUT(busy),
    .CHARGE_PUMP_ON_OUT(pump), .CORE_IGNORE_OUT(ign),
    .WRITE_DONE_IRQ_FLAG_OUT(done), .PGM_RD_IN(pgm_rd), .PGM_SPACE_IN(pgm_sp),
    .PGM_ADDR_IN(pgm_addr), .PGM_RDATA_OUT(pgm_rdata), .PGM_DENIED_OUT(denied)
  );
  nvac_cpu cpu (.clk_in(clk), .addr_out(baddr), .we_out(bwe), .re_out(bre),
    .wdata_out(bwd), .rdata_in(brd));
  // Compare and count
  task automatic chk(input [13:0] g, input [13:0] e);
    check_count = check_count + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Counts, verdict, end of run
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Wait for a write to end, noting whether the pump ran
  task automatic wait_done;
    int k;
    k = 0;
    pseen = 1'b0;
    do begin
      @(posedge clk);
      #1;
      pseen = pseen | pump;
      k = k + 1;
    end while (busy !== 1'b0 && k < 100);
    chk(busy, 1'b0);
  endtask
  // Byte write with permit and unlock
  task automatic dwr(input [7:0] wa, input [7:0] wd);
    cpu.wr(9'h10D, wa);
    cpu.wr(9'h10C, wd);
    cpu.wr(9'h18C, 8'h04);
    cpu.unl(8'h06);
  endtask
  // Byte read from data space
  task automatic drd(input [7:0] ra, output [7:0] rv);
    cpu.wr(9'h10D, ra);
    cpu.wr(9'h18C, 8'h01);
    cpu.rd(9'h10C, rv);
  endtask
  // Word read from program space, past the ignored cycles
  task automatic prd(input [12:0] ra, output [13:0] rv);
    logic [7:0] lo, hi;
    cpu.wr(9'h10F, {3'h0, ra[12:8]});
    cpu.wr(9'h10D, ra[7:0]);
    cpu.wr(9'h18C, 8'h81);
    #1;
    chk(ign, 1'b1);
    repeat (2) @(posedge clk);
    #1;
    chk(ign, 1'b0);
    cpu.rd(9'h10C, lo);
    cpu.rd(9'h10E, hi);
    chk(hi[7:6], 2'h0);
    rv = {hi[5:0], lo};
  endtask
  // Four-word block load and launch
  task automatic pwr(input [12:0] base);
    for (int j = 0; j < 4; j = j + 1) begin
      pm[j] = $random(seed) & 32'h3FFF;
      cpu.wr(9'h10F, {3'h0, base[12:8]});
      cpu.wr(9'h10D, base[7:0] | j[7:0]);
      cpu.wr(9'h10C, pm[j][7:0]);
      cpu.wr(9'h10E, {2'h0, pm[j][13:8]});
      cpu.wr(9'h18C, 8'h84);
      cpu.unl(8'h86);
    end
  endtask
  // Watchdog on the whole run
  initial begin
    #200000;
    bad_count = bad_count + 1;
    $display("[FAIL] %0t run did not finish", $time);
    print_verdict;
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    ext_rst = 1'b0;
    wdog = 1'b0;
    dsmall = 1'b0;
    psmall = 1'b0;
    cprot = 1'b0;
    pgm_rd = 1'b0;
    pgm_sp = 1'b0;
    wp_en = 1'b0;
    pgm_addr = 13'h0000;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    cpu.rd(9'h18C, r);
    chk(r, 8'h00);
    cpu.wr(9'h18C, 8'h70);
    cpu.rd(9'h18C, r);
    chk(r, 8'h00);
    cpu.wr(9'h18D, 8'h5A);
    cpu.rd(9'h18D, r);
    chk(r, 8'h00);
    // First write: select and strobe held while busy
    a0 = $random(seed) & 32'h7F;
    d = $random(seed);
    dm[a0] = d;
    dwr(a0, d);
    cpu.wr(9'h18C, 8'h80);
    cpu.rd(9'h18C, r);
    chk(r, 8'h02);
    wait_done;
    chk(pseen, 1'b1);
    chk(done, 1'b1);
    cpu.rd(9'h18C, r);
    chk(r, 8'h00);
    cpu.rd(9'h00D, r);
    chk(r, 8'h10);
    cpu.wr(9'h00D, 8'h00);
    cpu.rd(9'h00D, r);
    chk(r, 8'h00);
    // Random writes and read-back
    for (int k = 0; k < 4; k = k + 1) begin
      a = ($random(seed) & 32'h7F) | 32'h80;
      d = $random(seed);
      dwr(a, d);
      wait_done;
      dm[a] = d;
      drd(a, r);
      chk(r, dm[a]);
    end
    // Permit off, then two broken unlock orders
    for (int k = 0; k < 3; k = k + 1) begin
      cpu.wr(9'h10D, a0);
      cpu.wr(9'h10C, ~d);
      cpu.wr(9'h18C, k == 0 ? 8'h00 : 8'h04);
      cpu.wr(9'h18D, k == 1 ? 8'hAA : 8'h55);
      cpu.wr(9'h18D, k == 2 ? 8'h55 : 8'hAA);
      cpu.wr(9'h18C, 8'h06);
      cpu.rd(9'h18C, r);
      chk(r, 8'h04);
      drd(a0, r);
      chk(r, dm[a0]);
    end
    // Small data part: wrap on read, no pump on write
    @(posedge clk);
    dsmall <= 1'b1;
    repeat (3) @(posedge clk);
    drd(a0 | 8'h80, r);
    chk(r, dm[a0]);
    dwr(a0 | 8'h80, ~r);
    wait_done;
    chk(pseen, 1'b0);
    drd(a0, r);
    chk(r, dm[a0]);
    dsmall <= 1'b0;
    // Program block write, read, then wrap on small part
    pa = $random(seed) & 32'h0FFC;
    pwr(pa);
    wait_done;
    for (int k = 0; k < 4; k = k + 1) begin
      prd(pa | k[12:0], w);
      chk(w, pm[k]);
    end
    @(posedge clk);
    psmall <= 1'b1;
    repeat (3) @(posedge clk);
    for (int k = 0; k < 4; k = k + 1) begin
      prd(pa | k[12:0] | 13'h1000, w);
      chk(w, pm[k]);
    end
    // Warm resets in mid-write
    for (int k = 0; k < 2; k = k + 1) begin
      a = ($random(seed) & 32'h7F) | 32'h80;
      d = $random(seed);
      dwr(a, d);
      repeat (3) @(posedge clk);
      wdog <= (k == 0);
      ext_rst <= (k == 1);
      @(posedge clk);
      wdog <= 1'b0;
      ext_rst <= 1'b0;
      wait_done;
      cpu.rd(9'h18C, r);
      chk(r, 8'h08);
      cpu.rd(9'h10C, r);
      chk(r, d);
      cpu.rd(9'h10D, r);
      chk(r, a);
      cpu.wr(9'h18C, 8'h00);
    end
    // Programming port open, then shut by code protection
    for (int k = 0; k < 3; k = k + 1) begin
      @(posedge clk);
      cprot <= (k == 2);
      pgm_sp <= (k == 1);
      pgm_addr <= k == 1 ? pa : {5'h00, a0};
      pgm_rd <= 1'b1;
      @(posedge clk);
      pgm_rd <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk(pgm_rdata, k == 2 ? 14'h0000 : k == 1 ? pm[0][13:0] : dm[a0][13:0]);
      chk(denied, k == 2);
      drd(a0, r);
      chk(r, dm[a0]);
    end
    // Protected block: launch refused, old words kept
    wp_en <= 1'b1;
    cpu.wr(9'h10F, {3'h0, pa[12:8]});
    cpu.wr(9'h10D, pa[7:0] | 8'h03);
    cpu.wr(9'h10C, 8'h00);
    cpu.wr(9'h18C, 8'h84);
    cpu.unl(8'h86);
    cpu.rd(9'h18C, r);
    chk(r, 8'h84);
    prd(pa | 13'h0003, w);
    chk(w, pm[3]);
    print_verdict;
  end
endmodule
